// file: hw/msc_pkg.sv
package msc_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] MSC_OFF_CTRL     = 8'h00;
  localparam logic [7:0] MSC_OFF_STATUS   = 8'h04;
  localparam logic [7:0] MSC_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] MSC_OFF_IRQ_MASK = 8'h0C;
  // Control fields
  localparam int MSC_CTRL_REDUN_BIT   = 0;
  localparam int MSC_CTRL_STANDBY_BIT = 1;
  localparam int MSC_CTRL_LOCALON_BIT = 2;
  localparam logic [2:0] MSC_CTRL_RST = 3'h0;
  // Status fields
  localparam int MSC_ST_SEL_BIT   = 0;
  localparam int MSC_ST_RELAY_BIT = 1;
  localparam int MSC_ST_PEER_BIT  = 2;
  localparam int MSC_ST_OWN_BIT   = 3;
  localparam int MSC_ST_RCS_LSB   = 4;
  // Event bits
  localparam int MSC_EV_FAIL_BIT  = 0;
  localparam int MSC_EV_RECOV_BIT = 1;
  localparam int MSC_EV_SEL_BIT   = 2;
  localparam int MSC_EV_N         = 3;
  localparam logic [MSC_EV_N-1:0] MSC_EV_RST = 3'h0;
  // Glitch filter terminal count; a change must persist eight clock cycles
  localparam logic [2:0] MSC_FILT_MAX = 3'h7;
  // AXI responses
  localparam logic [1:0] MSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MSC_RESP_SLVERR = 2'h2;

  // Redundant-control status code
  typedef enum logic [1:0] {
    MSC_RCS_OFF = 2'h0,
    MSC_RCS_ON  = 2'h1,
    MSC_RCS_NA  = 2'h2
  } msc_rcs_e;

  // Shared operating signals
  typedef struct packed {
    logic [15:0] transmit_audio;
    logic [15:0] receive_audio;
    logic        ptt;
    logic        call;
  } msc_ops_s;
  localparam msc_ops_s MSC_OPS_RST = '0;
endpackage

// file: hw/msc_top.sv
// Summary of operation
// - After reset or with no failure the main unit holds the antenna.
// - Health output is zero when healthy; any nonzero peer health means failure.
// - Standby switches relay to itself when peer health goes nonzero.
// - Standby switches relay back to main when peer health returns to zero.
// - A failed standby keeps its relay command at rest contact.
// - Selection indicator lit only while this unit is selected.
// - Shared audio, PTT and call acted on only by the selected unit.
// - With redundancy enabled, on/off control follows redundancy, not local control.
// - Status ON on selected unit, OFF on the other, swapping on main failure.
// - With redundancy disabled the status reads not-applicable.
// - Only standby drives relay; normally common contact rests on main.
`timescale 1ns/100ps
`default_nettype none
module msc_top (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            rstn,
  // AXI4-Lite write
  input  wire logic [7:0]      s_awaddr,
  input  wire logic            s_awvalid,
  output var  logic            s_awready,
  input  wire logic [31:0]     s_wdata,
  input  wire logic [3:0]      s_wstrb,
  input  wire logic            s_wvalid,
  output var  logic            s_wready,
  output var  logic [1:0]      s_bresp,
  output var  logic            s_bvalid,
  input  wire logic            s_bready,
  // AXI4-Lite read
  input  wire logic [7:0]      s_araddr,
  input  wire logic            s_arvalid,
  output var  logic            s_arready,
  output var  logic [31:0]     s_rdata,
  output var  logic [1:0]      s_rresp,
  output var  logic            s_rvalid,
  input  wire logic            s_rready,
  // Health link to peer
  input  wire logic            own_fault,
  input  wire logic            peer_health_in,
  output var  logic            own_health_out,
  // Relay, indicator, radio control
  output var  logic            relay_cmd,
  output var  logic            status_led,
  output var  logic            radio_on,
  output var  logic [1:0]      redun_status,
  // Shared operating signals
  input  wire msc_pkg::msc_ops_s ops_in,
  output var  msc_pkg::msc_ops_s ops_out,
  // Interrupt
  output var  logic            irq
);
  import msc_pkg::*;

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;
  // Two stages so release is clean against the clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // Registers and bus
  // ************************************************************
  logic [2:0]          ctrl_q;
  logic [MSC_EV_N-1:0] ev_q;
  logic [MSC_EV_N-1:0] mask_q;
  logic [MSC_EV_N-1:0] ev_set;
  logic [7:0]          awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                aw_have_q;
  logic                w_have_q;
  logic                wr_go;
  logic [31:0]         rd_word;
  logic                rd_hit;
  logic                redun_en;
  logic                is_standby;
  logic                sel_q;
  logic                peer_fail_q;
  logic                relay_q;
  logic                own_fault_q;
  msc_rcs_e            rcs_q;

  assign redun_en   = ctrl_q[MSC_CTRL_REDUN_BIT];
  assign is_standby = ctrl_q[MSC_CTRL_STANDBY_BIT];
  assign wr_go      = aw_have_q && w_have_q && !s_bvalid;

  // Address and data captured independently, in either order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end else begin
      s_awready <= !aw_have_q && !s_awready && !s_awvalid ? 1'b1 : !aw_have_q && !s_awready;
      s_wready  <= !w_have_q && !s_wready;
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_wdata;
        // Strobe is only valid with wvalid, so keep it with the data
        wstrb_q  <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_bvalid <= 1'b0;
      s_bresp  <= MSC_RESP_OKAY;
    end else if (wr_go) begin
      s_bvalid <= 1'b1;
      s_bresp  <= (awaddr_q == MSC_OFF_CTRL || awaddr_q == MSC_OFF_IRQ_STAT ||
                   awaddr_q == MSC_OFF_IRQ_MASK) ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Control and mask; byte lane 0 carries every writable bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= MSC_CTRL_RST;
      mask_q <= MSC_EV_RST;
    end else if (wr_go && wstrb_q[0]) begin
      if (awaddr_q == MSC_OFF_CTRL) begin
        ctrl_q <= wdata_q[2:0];
      end
      if (awaddr_q == MSC_OFF_IRQ_MASK) begin
        mask_q <= wdata_q[MSC_EV_N-1:0];
      end
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ev_q <= MSC_EV_RST;
    end else if (wr_go && wstrb_q[0] && awaddr_q == MSC_OFF_IRQ_STAT) begin
      ev_q <= (ev_q & ~wdata_q[MSC_EV_N-1:0]) | ev_set;
    end else begin
      ev_q <= ev_q | ev_set;
    end
  end

  // Interrupt level from unmasked sticky bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_q & mask_q);
    end
  end

  // Read mux; unmapped offsets answer SLVERR with zero data
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    case (s_araddr)
      MSC_OFF_CTRL:     rd_word[2:0] = ctrl_q;
      MSC_OFF_STATUS: begin
        rd_word[MSC_ST_SEL_BIT]   = sel_q;
        rd_word[MSC_ST_RELAY_BIT] = relay_q;
        rd_word[MSC_ST_PEER_BIT]  = peer_fail_q;
        rd_word[MSC_ST_OWN_BIT]   = own_fault_q;
        rd_word[MSC_ST_RCS_LSB+:2] = rcs_q;
      end
      MSC_OFF_IRQ_STAT: rd_word[MSC_EV_N-1:0] = ev_q;
      MSC_OFF_IRQ_MASK: rd_word[MSC_EV_N-1:0] = mask_q;
      default:          rd_hit = 1'b0;
    endcase
  end

  // One read at a time, data one cycle after the address
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= MSC_RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !s_arready;
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid  <= 1'b1;
        s_rdata   <= rd_word;
        s_rresp   <= rd_hit ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Peer health conditioning
  // ************************************************************
  logic [1:0] peer_sync_q;
  logic [2:0] filt_cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      peer_sync_q <= 2'h0;
    end else begin
      peer_sync_q <= {peer_sync_q[0], peer_health_in};
    end
  end

  // glitch filter; a change must persist before it is believed
  // any nonzero level counts as failure
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      filt_cnt_q  <= 3'h0;
      peer_fail_q <= 1'b0;
    end else if (peer_sync_q[1] == peer_fail_q) begin
      filt_cnt_q <= 3'h0;
    end else if (filt_cnt_q == MSC_FILT_MAX) begin
      filt_cnt_q  <= 3'h0;
      peer_fail_q <= peer_sync_q[1];
    end else begin
      filt_cnt_q <= filt_cnt_q + 3'h1;
    end
  end

  // ************************************************************
  // Changeover decision
  // ************************************************************
  logic sel_d;
  // in redundancy main rests selected, standby only via its relay; without it local control selects
  always_comb begin
    if (!redun_en) begin
      sel_d = ctrl_q[MSC_CTRL_LOCALON_BIT];
    end else if (is_standby) begin
      sel_d = peer_fail_q && !own_fault;
    end else begin
      sel_d = !own_fault || peer_fail_q;
    end
  end

  assign ev_set[MSC_EV_FAIL_BIT]  = (peer_sync_q[1] != peer_fail_q) && peer_sync_q[1] &&
                                    (filt_cnt_q == MSC_FILT_MAX);
  assign ev_set[MSC_EV_RECOV_BIT] = (peer_sync_q[1] != peer_fail_q) && !peer_sync_q[1] &&
                                    (filt_cnt_q == MSC_FILT_MAX);
  assign ev_set[MSC_EV_SEL_BIT]   = sel_d != sel_q;

  // only a healthy standby in redundancy moves the relay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      relay_q        <= 1'b0;
      own_fault_q    <= 1'b0;
      own_health_out <= 1'b0;
    end else begin
      relay_q        <= redun_en && is_standby && peer_fail_q && !own_fault;
      own_fault_q    <= own_fault;
      // zero on the link means proper operation
      own_health_out <= own_fault;
    end
  end
  assign relay_cmd = relay_q;

  // indicator, on/off override and status code
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_q        <= 1'b0;
      status_led   <= 1'b0;
      radio_on     <= 1'b0;
      rcs_q        <= MSC_RCS_NA;
      redun_status <= MSC_RCS_NA;
    end else begin
      sel_q        <= sel_d;
      status_led   <= sel_d;
      radio_on     <= redun_en ? sel_d : ctrl_q[MSC_CTRL_LOCALON_BIT];
      rcs_q        <= !redun_en ? MSC_RCS_NA : (sel_d ? MSC_RCS_ON : MSC_RCS_OFF);
      redun_status <= !redun_en ? MSC_RCS_NA : (sel_d ? MSC_RCS_ON : MSC_RCS_OFF);
    end
  end

  // shared signals pass only on the selected unit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ops_out <= MSC_OPS_RST;
    end else begin
      ops_out <= sel_d ? ops_in : MSC_OPS_RST;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  relay_rest_main_a: assert property (!$past(is_standby) |-> !relay_q)
    else $error("main unit drove relay");
  relay_fail_rest_a: assert property ($past(own_fault) |-> !relay_q)
    else $error("failed standby moved relay");
  relay_switch_a: assert property (redun_en && is_standby && !own_fault
                                   && $rose(peer_fail_q) && $stable(ctrl_q) |=> relay_q)
    else $error("standby did not take antenna");
  relay_back_a: assert property (redun_en && $fell(peer_fail_q) |=> !relay_q)
    else $error("relay not returned to main");
  filter_len_a: assert property ($changed(peer_fail_q) |-> $past(filt_cnt_q) == MSC_FILT_MAX)
    else $error("peer level accepted without filtering");
  // A three-cycle pulse must leave the accepted level untouched
  filter_glitch_a: assert property ($changed(peer_sync_q[1])
                                    ##1 $stable(peer_sync_q[1])[*2] ##1 $changed(peer_sync_q[1])
                                    |-> $stable(peer_fail_q) ##1 $stable(peer_fail_q))
    else $error("glitch reached decision");
  led_sel_a: assert property ($past(redun_en && is_standby) |-> status_led == relay_q)
    else $error("indicator differs from selection");
  gate_ops_a: assert property (!sel_q |-> ops_out == MSC_OPS_RST)
    else $error("unselected unit passed shared signals");
  radio_override_a: assert property ($past(redun_en) |-> radio_on == sel_q)
    else $error("on/off not overridden");
  status_code_a: assert property (redun_en && $stable(ctrl_q) |=>
                                  redun_status == (sel_q ? MSC_RCS_ON : MSC_RCS_OFF))
    else $error("status code wrong");
  status_na_a: assert property (!redun_en && $stable(ctrl_q) |=> redun_status == MSC_RCS_NA)
    else $error("status not n/a");
  main_default_a: assert property (redun_en && !is_standby && !own_fault && $stable(ctrl_q)
                                   |=> sel_q)
    else $error("healthy main not selected");
  health_out_a: assert property ($past(own_fault) == own_health_out)
    else $error("health output wrong");

  switch_over_c: cover property (is_standby && $rose(relay_q));
  switch_back_c: cover property (is_standby && $fell(relay_q));
  irq_raise_c: cover property ($rose(irq));
  na_mode_c: cover property (redun_status == MSC_RCS_NA ##1 redun_status == MSC_RCS_ON);
endmodule
`default_nettype wire

// file: tb/msc_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module msc_peer_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Commands from the bench
  input  wire logic fail_cmd,
  input  wire logic glitch,
  // Health level towards the unit under test
  output var  logic peer_health
);
  logic [1:0] glitch_q;

  // ****************************************
  // Peer health output
  // ****************************************
  // health level zero
  // Zero while healthy; a three-cycle pulse mimics cable noise
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      glitch_q    <= 2'h0;
      peer_health <= 1'b0;
    end else begin
      glitch_q    <= glitch ? 2'h3 : glitch_q - {1'b0, |glitch_q};
      peer_health <= fail_cmd | (|glitch_q);
    end
  end
endmodule
`default_nettype wire

// file: tb/msc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module msc_top_tb;
  import msc_pkg::*;
  logic        clock, rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, resp, redun_status;
  logic        own_fault, peer_health_in, own_health_out, relay_cmd, status_led, radio_on;
  logic        fail_cmd, glitch;
  logic [2:0]  ctrl;
  msc_ops_s    ops_in, ops_out;
  int          bad_count, n_compared, seed;

  msc_top i_dut (.clock, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .own_fault, .peer_health_in, .own_health_out,
    .relay_cmd, .status_led, .radio_on, .redun_status, .ops_in, .ops_out, .irq);
  msc_peer_model i_peer (.clock, .rstn, .fail_cmd, .glitch, .peer_health(peer_health_in));

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ****************************************
  // Bench helpers
  // ****************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_q, w_q;
    aw_q = 1'b0;
    w_q = 1'b0;
    @(posedge clock);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_q && w_q)) begin
      @(posedge clock);
      if (s_awready && !aw_q) begin
        aw_q = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wready && !w_q) begin
        w_q = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_bvalid !== 1'b1);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clock);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clock); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge clock); while (s_rvalid !== 1'b1);
    rd = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask

  // Which unit should hold the antenna, from role, faults and enables
  function automatic logic exp_sel(input logic [2:0] c, input logic own_f, input logic peer_f);
    if (!c[MSC_CTRL_REDUN_BIT]) return c[MSC_CTRL_LOCALON_BIT];
    if (c[MSC_CTRL_STANDBY_BIT]) return peer_f && !own_f;
    return !own_f || peer_f;
  endfunction

  // Compares indicator, relay, on/off, status and health outputs, then pushes random shared traffic through
  task automatic check_unit(input logic [2:0] c, input logic peer_f);
    logic        sel;
    logic [1:0]  rcs;
    logic [63:0] r64;
    msc_ops_s    rnd;
    sel = exp_sel(c, own_fault, peer_f);
    rcs = !c[0] ? MSC_RCS_NA : (sel ? MSC_RCS_ON : MSC_RCS_OFF);
    r64 = {$random(seed), $random(seed)};
    rnd = r64[33:0];
    chk("status_led", {31'h0, sel}, {31'h0, status_led});
    chk("relay_cmd", {31'h0, sel & c[1] & c[0]}, {31'h0, relay_cmd});
    chk("radio_on", {31'h0, sel}, {31'h0, radio_on});
    chk("redun_status", {30'h0, rcs}, {30'h0, redun_status});
    chk("own_health_out", {31'h0, own_fault}, {31'h0, own_health_out});
    ops_in <= rnd;
    cyc(3);
    chk("ops_out", {30'h0, sel ? rnd[33:32] : 2'h0}, {30'h0, ops_out[33:32]});
    chk("ops_audio", sel ? rnd[31:0] : 32'h0, ops_out[31:0]);
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    seed = 61;
    {rstn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, own_fault, fail_cmd} = '0;
    {glitch, s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    ops_in = MSC_OPS_RST;
    cyc(2);
    rstn <= 1'b1;
    cyc(4);
    chk("rst_status", {30'h0, MSC_RCS_NA}, {30'h0, redun_status});
    chk("rst_relay", 32'h0, {31'h0, relay_cmd});
    axi_rd(MSC_OFF_CTRL);
    chk("ctrl_rst", {29'h0, MSC_CTRL_RST}, rd);
    axi_rd(MSC_OFF_IRQ_MASK);
    chk("mask_rst", 32'h0, rd);
    axi_rd(8'h10);
    chk("unmapped_resp", {30'h0, MSC_RESP_SLVERR}, {30'h0, resp});
    axi_wr(MSC_OFF_STATUS, 32'h7);
    chk("ro_resp", {30'h0, MSC_RESP_SLVERR}, {30'h0, resp});
    s_wstrb <= 4'h0;
    axi_wr(MSC_OFF_IRQ_MASK, 32'h7);
    chk("strb_resp", {30'h0, MSC_RESP_OKAY}, {30'h0, resp});
    s_wstrb <= 4'hF;
    axi_rd(MSC_OFF_IRQ_MASK);
    chk("strb_ignored", 32'h0, rd);
    $display("test reset and registers done");
    axi_wr(MSC_OFF_CTRL, 32'h3);
    axi_wr(MSC_OFF_IRQ_MASK, 32'h1);
    cyc(4);
    check_unit(3'h3, 1'b0);
    glitch <= 1'b1;
    cyc(1);
    glitch <= 1'b0;
    cyc(16);
    check_unit(3'h3, 1'b0);
    fail_cmd <= 1'b1;
    cyc(16);
    check_unit(3'h3, 1'b1);
    chk("irq_set", 32'h1, {31'h0, irq});
    axi_rd(MSC_OFF_STATUS);
    chk("status_reg", {26'h0, MSC_RCS_ON, 4'h7}, rd);
    axi_rd(MSC_OFF_IRQ_STAT);
    chk("irq_stat", 32'h5, rd);
    axi_wr(MSC_OFF_IRQ_STAT, 32'h5);
    axi_rd(MSC_OFF_IRQ_STAT);
    chk("irq_clr", 32'h0, rd);
    cyc(2);
    chk("irq_low", 32'h0, {31'h0, irq});
    own_fault <= 1'b1;
    cyc(4);
    check_unit(3'h3, 1'b1);
    own_fault <= 1'b0;
    cyc(4);
    fail_cmd <= 1'b0;
    cyc(16);
    check_unit(3'h3, 1'b0);
    $display("test standby changeover done");
    axi_wr(MSC_OFF_CTRL, 32'h1);
    cyc(4);
    check_unit(3'h1, 1'b0);
    repeat (10) begin
      ctrl = 3'($random(seed));
      own_fault <= 1'($random(seed));
      fail_cmd <= 1'($random(seed));
      axi_wr(MSC_OFF_CTRL, {29'h0, ctrl});
      cyc(16);
      check_unit(ctrl, fail_cmd);
    end
    $display("test random modes done");
    wrap_up();
  end
endmodule
`default_nettype wire
